// [core/supply_monitor_self_test.sv]
// supply monitor self-test: regulator monitor chopping, oscillator cross check, ground-loss test
// Overview of operation
// RL1 - chop monitor comparators, XOR, flag non-toggle
// RL2 - self-test runs while enable bit set
// RL3 - under-voltage test fail: reset, two flags
// RL4 - over-voltage test fail: reset, two flags
// RL5 - shared enable bit 16, fault bit 10
// RL6 - host re-enables test after recovery
// RL7 - oscillator drift: power down, reset, disable
// RL8 - safe state until fault gone or wake
// RL9 - oscillator mismatch outside -17..+20 percent
// RL10 - stuck oscillator after 8 us silence
// RL11 - oscillator fault asserts resets, sets bit 15
// RL12 - ground-loss test starts after trim download
// RL13 - ground-loss fails set bits 10/11, no reset
// RL14 - ground-loss test 32 us, 16 us chop
// RL15 - fault set wins over read clear
`include "supply_monitor_self_test_cfg.svh"

module supply_monitor_self_test #(
    parameter int MON_HALF   = `MON_CHOP_HALF_CYC,
    parameter int GND_HALF   = `GND_CHOP_HALF_CYC,
    parameter int GND_TEST   = `GND_TEST_CYC,
    parameter int RESET_HOLD = `RESET_HOLD_CYC,
    parameter int PWR_DOWN   = `PWR_DOWN_CYC,
    parameter int OSC_WINDOW = `OSC_WINDOW_CYC,
    parameter int OSC_STUCK  = `OSC_STUCK_CYC
) (
    input  wire logic                      sys_clk,
    input  wire logic                      rst,
    input  wire logic                      service_enable_wr,
    input  wire supply_monitor_pkg::reg_word_t service_enable_wdata,
    output supply_monitor_pkg::reg_word_t  service_enable_rdata,
    input  wire logic                      service_fault_rd,
    output supply_monitor_pkg::reg_word_t  service_fault_rdata,
    input  wire logic                      temperature_sensor_rd,
    output supply_monitor_pkg::reg_word_t  temperature_sensor_rdata,
    input  wire logic                      supply_status_rd,
    output logic [1:0]                     uv_fault_flag,
    output logic [1:0]                     ov_fault_flag,
    output logic                           mon_chop_clk,
    input  wire logic [3:0]                mon_cmp_out,
    input  wire logic                      ref_osc,
    input  wire logic                      wake,
    input  wire logic                      trim_done,
    output logic                           gnd_chop_clk,
    input  wire logic [1:0]                gnd_cmp_out,
    output logic                           gnd_test_busy,
    output logic                           reset_out_primary_n,
    output logic                           reset_out_secondary_n,
    output logic                           channels_disable
);
    import supply_monitor_pkg::*;

    localparam int MW  = $clog2(MON_HALF);
    localparam int GHW = $clog2(GND_HALF);
    localparam int GW  = $clog2(GND_TEST);
    localparam int SW  = $clog2(RESET_HOLD + PWR_DOWN + 1);
    localparam logic [MW-1:0]  MON_LAST   = MW'(MON_HALF - 1);
    localparam logic [GHW-1:0] GND_HLAST  = GHW'(GND_HALF - 1);
    localparam logic [GW-1:0]  GND_LAST   = GW'(GND_TEST - 1);
    localparam logic [SW-1:0]  HOLD_LAST  = SW'(RESET_HOLD - 1);
    localparam logic [SW-1:0]  PD_LAST    = SW'(PWR_DOWN - 1);

    if (MON_HALF < 2 || GND_HALF < 2 || GND_TEST < 2 * GND_HALF || RESET_HOLD < 1 || PWR_DOWN < 1)
    begin : g_bad_param
        $error("supply_monitor_self_test: timing parameter out of range");
    end

    pwr_state_t     pwr_state_reg;
    logic [SW-1:0]  state_cnt_reg;
    logic           st_enable_reg;
    logic [MW-1:0]  mon_cnt_reg;
    logic           mon_active;
    logic           mon_sample;
    logic [3:0]     mon_fail;
    logic           st_flag_reg;
    logic           osc_flag_reg;
    logic           osc_fault;
    logic           wake_q;
    logic           wake_edge;
    logic           trim_done_q;
    logic           gnd_start;
    logic [GW-1:0]  gnd_cnt_reg;
    logic [GHW-1:0] gnd_hcnt_reg;
    logic           gnd_sample;
    logic [1:0]     gnd_fail;
    logic [1:0]     gnd_flag_reg;

    // wake and trim_done are synchronous pins; only their edges matter
    assign wake_edge = wake ^ wake_q;
    assign gnd_start = trim_done & ~trim_done_q;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wake_q      <= 1'b0;
            trim_done_q <= 1'b0;
        end else begin
            wake_q      <= wake;
            trim_done_q <= trim_done;
        end
    end

    // RL2 enable held until host clears it or the state machine enters PS_RESET
    // RL6 device reset drops the enable, host must rewrite it
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_enable_reg <= 1'b0;
        end else if (pwr_state_reg == PS_RESET) begin
            st_enable_reg <= 1'b0;
        end else if (service_enable_wr) begin
            st_enable_reg <= service_enable_wdata[`SVC_EN_ST_BIT];
        end
    end

    // chopping only while running: a check during reset would chase its own fault
    assign mon_active = st_enable_reg && (pwr_state_reg == PS_RUN);
    assign mon_sample = mon_active && (mon_cnt_reg == MON_LAST);

    // RL1 diagnostic chop clock
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            mon_cnt_reg  <= '0;
            mon_chop_clk <= 1'b0;
        end else if (!mon_active) begin
            mon_cnt_reg  <= '0;
            mon_chop_clk <= 1'b0;
        end else if (mon_sample) begin
            mon_cnt_reg  <= '0;
            mon_chop_clk <= ~mon_chop_clk;
        end else begin
            mon_cnt_reg <= mon_cnt_reg + MW'(1);
        end
    end

    // order: uv a, ov a, uv b, ov b; sampled at the end of each half period after settling
    for (genvar i = 0; i < 4; i++) begin : g_mon
        // RL1 XOR of output and chop
        assign mon_fail[i] = mon_sample && (mon_cmp_out[i] ^ mon_chop_clk);
    end

    // RL15 set wins over clear
    // RL3 under-voltage flag
    // RL4 over-voltage flag
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            uv_fault_flag <= 2'h0;
            ov_fault_flag <= 2'h0;
        end else begin
            uv_fault_flag <= {mon_fail[2], mon_fail[0]} | (uv_fault_flag & {2{~supply_status_rd}});
            ov_fault_flag <= {mon_fail[3], mon_fail[1]} | (ov_fault_flag & {2{~supply_status_rd}});
        end
    end

    // RL5 shared self-test fault bit
    // RL11 oscillator fault bit
    // RL15 set wins over clear
    // these flags are cleared by rst or a service fault read, not by PS_RESET, so they outlive the reset they cause
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_flag_reg  <= 1'b0;
            osc_flag_reg <= 1'b0;
        end else begin
            st_flag_reg  <= (|mon_fail) | (st_flag_reg & ~service_fault_rd);
            osc_flag_reg <= osc_fault | (osc_flag_reg & ~service_fault_rd);
        end
    end

    osc_monitor #(
        .WINDOW (OSC_WINDOW),
        .STUCK  (OSC_STUCK)
    ) u_osc_monitor (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .ref_osc   (ref_osc),
        .restart   (wake_edge && (pwr_state_reg == PS_SAFE)),
        .osc_fault (osc_fault)
    );

    // RL7 oscillator fault powers down
    // RL8 safe state exit and re-entry
    // RL3 self-test failure resets like a real fault
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pwr_state_reg <= PS_RESET;
            state_cnt_reg <= '0;
        end else begin
            unique case (pwr_state_reg)
                PS_RUN: begin
                    state_cnt_reg <= '0;
                    if (osc_fault) begin
                        pwr_state_reg <= PS_POWER_DOWN;
                    end else if (|mon_fail) begin
                        pwr_state_reg <= PS_RESET;
                    end
                end
                PS_POWER_DOWN: begin
                    if (state_cnt_reg == PD_LAST) begin
                        pwr_state_reg <= PS_SAFE;
                        state_cnt_reg <= '0;
                    end else begin
                        state_cnt_reg <= state_cnt_reg + SW'(1);
                    end
                end
                PS_SAFE: begin
                    state_cnt_reg <= '0;
                    if (!osc_fault || wake_edge) begin
                        pwr_state_reg <= PS_RESET;
                    end
                end
                PS_RESET: begin
                    if (osc_fault) begin
                        pwr_state_reg <= PS_POWER_DOWN;
                        state_cnt_reg <= '0;
                    end else if (state_cnt_reg == HOLD_LAST) begin
                        pwr_state_reg <= PS_RUN;
                        state_cnt_reg <= '0;
                    end else begin
                        state_cnt_reg <= state_cnt_reg + SW'(1);
                    end
                end
            endcase
        end
    end

    // RL11 both resets asserted
    assign reset_out_primary_n   = (pwr_state_reg == PS_RUN) || (pwr_state_reg == PS_POWER_DOWN);
    assign reset_out_secondary_n = reset_out_primary_n;
    // RL7 channels off outside run
    assign channels_disable      = (pwr_state_reg != PS_RUN);

    // RL12 start after trim download
    // RL14 test length and chop
    // one run per trim_done rise; a rise while busy is ignored
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            gnd_test_busy <= 1'b0;
            gnd_cnt_reg   <= '0;
            gnd_hcnt_reg  <= '0;
            gnd_chop_clk  <= 1'b0;
        end else if (!gnd_test_busy) begin
            gnd_test_busy <= gnd_start;
            gnd_cnt_reg   <= '0;
            gnd_hcnt_reg  <= '0;
            gnd_chop_clk  <= 1'b0;
        end else begin
            gnd_cnt_reg <= gnd_cnt_reg + GW'(1);
            if (gnd_cnt_reg == GND_LAST) begin
                gnd_test_busy <= 1'b0;
            end
            if (gnd_sample) begin
                gnd_hcnt_reg <= '0;
                gnd_chop_clk <= ~gnd_chop_clk;
            end else begin
                gnd_hcnt_reg <= gnd_hcnt_reg + GHW'(1);
            end
        end
    end

    assign gnd_sample = gnd_test_busy && (gnd_hcnt_reg == GND_HLAST);

    for (genvar j = 0; j < 2; j++) begin : g_gnd
        assign gnd_fail[j] = gnd_sample && (gnd_cmp_out[j] ^ gnd_chop_clk);
    end

    // RL13 warning flags only, no reset
    // RL15 set wins over clear
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            gnd_flag_reg <= 2'h0;
        end else begin
            gnd_flag_reg <= gnd_fail | (gnd_flag_reg & {2{~temperature_sensor_rd}});
        end
    end

    always_comb begin
        service_enable_rdata                     = `REG_RESET_VAL;
        service_enable_rdata[`SVC_EN_ST_BIT]     = st_enable_reg;
        service_fault_rdata                      = `REG_RESET_VAL;
        service_fault_rdata[`SVC_FLT_ST_BIT]     = st_flag_reg;
        service_fault_rdata[`SVC_FLT_OSC_BIT]    = osc_flag_reg;
        temperature_sensor_rdata                 = `REG_RESET_VAL;
        temperature_sensor_rdata[`TEMP_SENS_GND_BIT]  = gnd_flag_reg[0];
        temperature_sensor_rdata[`TEMP_SENS_GNDA_BIT] = gnd_flag_reg[1];
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    chop_period_a: assert property ($changed(mon_chop_clk) && $past(mon_active)
                                    |-> $past(mon_cnt_reg) == MON_LAST) // RL1
        else $error("chop clock toggled off its half period");
    xor_fault_a: assert property (mon_sample && (mon_cmp_out != {4{mon_chop_clk}}) |=> st_flag_reg) // RL1
        else $error("comparator mismatch not flagged");
    enable_keep_a: assert property (st_enable_reg && !service_enable_wr && pwr_state_reg != PS_RESET
                                    |=> st_enable_reg) // RL2
        else $error("self-test enable dropped on its own");
    uv_fail_a: assert property (mon_sample && (mon_cmp_out[0] ^ mon_chop_clk) && !osc_fault
                                |=> uv_fault_flag[0] && st_flag_reg && !reset_out_primary_n) // RL3
        else $error("under-voltage self-test fail not handled");
    ov_fail_a: assert property (mon_sample && (mon_cmp_out[3] ^ mon_chop_clk) && !osc_fault
                                |=> ov_fault_flag[1] && service_fault_rdata[`SVC_FLT_ST_BIT]
                                    && !reset_out_secondary_n) // RL4
        else $error("over-voltage self-test fail not handled");
    enable_bit_a: assert property (service_enable_wr && pwr_state_reg != PS_RESET
                                   |=> st_enable_reg == $past(service_enable_wdata[`SVC_EN_ST_BIT])) // RL5
        else $error("enable bit not taken from bit 16");
    osc_pd_a: assert property (pwr_state_reg == PS_RUN && osc_fault
                               |=> channels_disable && pwr_state_reg == PS_POWER_DOWN) // RL7
        else $error("oscillator fault did not power down");
    safe_hold_a: assert property (pwr_state_reg == PS_SAFE && osc_fault && !wake_edge
                                  |=> pwr_state_reg == PS_SAFE && !reset_out_primary_n) // RL8
        else $error("safe state left while fault present");
    osc_flag_a: assert property (osc_fault |=> service_fault_rdata[`SVC_FLT_OSC_BIT]) // RL11
        else $error("oscillator fault bit not set");
    pd_reset_a: assert property (pwr_state_reg == PS_POWER_DOWN && state_cnt_reg == PD_LAST
                                 |=> !reset_out_primary_n && !reset_out_secondary_n) // RL11
        else $error("resets not asserted after power down");
    gnd_start_a: assert property (gnd_start && !gnd_test_busy |=> gnd_test_busy) // RL12
        else $error("ground-loss test did not start");
    gnd_len_a: assert property ($fell(gnd_test_busy) |-> $past(gnd_cnt_reg) == GND_LAST) // RL14
        else $error("ground-loss test length wrong");
    gnd_noreset_a: assert property (gnd_fail != 2'h0 && pwr_state_reg == PS_RUN // RL13
                                    && !osc_fault && mon_fail == 4'h0
                                    |=> pwr_state_reg == PS_RUN && (gnd_flag_reg & $past(gnd_fail)) == $past(gnd_fail))
        else $error("ground-loss fail mishandled");
    set_wins_a: assert property ((|mon_fail) && service_fault_rd |=> st_flag_reg) // RL15
        else $error("self-test fault lost to read clear");

    st_reset_c: cover property (mon_sample && mon_fail != 4'h0 ##1 pwr_state_reg == PS_RESET);
    osc_safe_c: cover property (pwr_state_reg == PS_SAFE ##1 pwr_state_reg == PS_RESET);
    gnd_fail_c: cover property (gnd_flag_reg == 2'h3);
endmodule : supply_monitor_self_test

// [core/supply_monitor_self_test_cfg.svh]
// clock rate, field positions, reset values and timing counts of the supply self-test block
`ifndef SUPPLY_MONITOR_SELF_TEST_CFG_SVH
`define SUPPLY_MONITOR_SELF_TEST_CFG_SVH

`define SYS_CLK_MHZ         50
`define REG_W               20
`define REG_RESET_VAL       20'h0_0000

`define SVC_EN_ST_BIT       16
`define SVC_FLT_ST_BIT      10
`define SVC_FLT_OSC_BIT     15
`define TEMP_SENS_GND_BIT   10
`define TEMP_SENS_GNDA_BIT  11

`define MON_CHOP_PERIOD_US  64
`define MON_CHOP_HALF_CYC   ((`MON_CHOP_PERIOD_US * `SYS_CLK_MHZ) / 2)
`define GND_CHOP_PERIOD_US  16
`define GND_CHOP_HALF_CYC   ((`GND_CHOP_PERIOD_US * `SYS_CLK_MHZ) / 2)
`define GND_TEST_US         32
`define GND_TEST_CYC        (`GND_TEST_US * `SYS_CLK_MHZ)

`define REF_OSC_MHZ         16
`define OSC_STUCK_US        8
`define OSC_STUCK_CYC       (`OSC_STUCK_US * `SYS_CLK_MHZ)
`define OSC_WINDOW_CYC      3125
`define OSC_ERR_LO_PCT      17
`define OSC_ERR_HI_PCT      20

`define RESET_HOLD_CYC      100
`define PWR_DOWN_CYC        50

`endif

// [core/supply_monitor_pkg.sv]
// types shared by the supply self-test block
`include "supply_monitor_self_test_cfg.svh"

package supply_monitor_pkg;
    typedef enum logic [1:0] {PS_RUN, PS_POWER_DOWN, PS_SAFE, PS_RESET} pwr_state_t;
    typedef logic [`REG_W-1:0] reg_word_t;
endpackage : supply_monitor_pkg

// [core/osc_monitor.sv]
// reference-oscillator cross check: frequency window and stuck timeout
`include "supply_monitor_self_test_cfg.svh"

module osc_monitor #(
    parameter int WINDOW = `OSC_WINDOW_CYC,
    parameter int STUCK  = `OSC_STUCK_CYC
) (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic ref_osc,
    input  wire logic restart,
    output logic      osc_fault
);
    localparam int NOM = (WINDOW * `REF_OSC_MHZ) / `SYS_CLK_MHZ;
    localparam int LO  = (NOM * (100 - `OSC_ERR_LO_PCT)) / 100;
    localparam int HI  = (NOM * (100 + `OSC_ERR_HI_PCT)) / 100;
    localparam int WW  = $clog2(WINDOW);
    localparam int EW  = $clog2(WINDOW + 1);
    localparam int SW  = $clog2(STUCK + 1);
    localparam logic [WW-1:0] WIN_LAST = WW'(WINDOW - 1);
    localparam logic [EW-1:0] LO_E     = EW'(LO);
    localparam logic [EW-1:0] HI_E     = EW'(HI);
    localparam logic [SW-1:0] STUCK_E  = SW'(STUCK);

    if (WINDOW < 16 || STUCK < 2 || LO < 1) begin : g_bad_param
        $error("osc_monitor: window or stuck timeout too short");
    end

    logic          ref_q;
    logic [WW-1:0] win_cnt_reg;
    logic [EW-1:0] edge_cnt_reg;
    logic [SW-1:0] stuck_cnt_reg;
    logic          ref_edge;
    logic          win_end;
    logic          stuck;
    logic [EW-1:0] edge_total;

    // the reference pin is taken as synchronous, so no synchroniser stage
    assign ref_edge   = ref_osc & ~ref_q;
    assign win_end    = (win_cnt_reg == WIN_LAST);
    assign edge_total = edge_cnt_reg + EW'(ref_edge);
    // RL10 stuck timeout
    assign stuck      = (stuck_cnt_reg == STUCK_E);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ref_q <= 1'b0;
        end else begin
            ref_q <= ref_osc;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            win_cnt_reg  <= '0;
            edge_cnt_reg <= '0;
        end else if (restart || win_end) begin
            win_cnt_reg  <= '0;
            edge_cnt_reg <= '0;
        end else begin
            win_cnt_reg  <= win_cnt_reg + WW'(1);
            edge_cnt_reg <= edge_total;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stuck_cnt_reg <= '0;
        end else if (restart || ref_edge) begin
            stuck_cnt_reg <= '0;
        end else if (!stuck) begin
            stuck_cnt_reg <= stuck_cnt_reg + SW'(1);
        end
    end

    // RL9 window count outside band
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            osc_fault <= 1'b0;
        end else if (restart) begin
            osc_fault <= 1'b0;
        end else if (stuck) begin
            osc_fault <= 1'b1;
        end else if (win_end) begin
            osc_fault <= (edge_total < LO_E) || (edge_total > HI_E);
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    stuck_fault_a: assert property (stuck && !restart |=> osc_fault) // RL10
        else $error("stuck reference not flagged");
    band_fault_a: assert property (win_end && !stuck && !restart && (edge_total < LO_E || edge_total > HI_E)
                                   |=> osc_fault) // RL9
        else $error("out-of-band count not flagged");
    band_ok_a: assert property (win_end && !stuck && !restart && edge_total >= LO_E && edge_total <= HI_E
                                |=> !osc_fault) // RL9
        else $error("in-band count flagged as fault");
    stuck_seen_c: cover property (stuck);
endmodule : osc_monitor

// [verification/analog_side_model.sv]
// model of the analog side: monitor and ground comparators, reference oscillator
module analog_side_model (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       mon_chop_clk,
    input  wire logic       gnd_chop_clk,
    input  wire logic [3:0] mon_stuck,
    input  wire logic [1:0] gnd_stuck,
    input  wire logic       stuck_lvl,
    input  wire logic [4:0] osc_rate,
    output logic [3:0]      mon_cmp_out,
    output logic [1:0]      gnd_cmp_out,
    output logic            ref_osc
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] acc_reg;
    assign mon_cmp_out = (mon_stuck & {4{stuck_lvl}}) | (~mon_stuck & {4{mon_chop_clk}});
    assign gnd_cmp_out = (gnd_stuck & {2{stuck_lvl}}) | (~gnd_stuck & {2{gnd_chop_clk}});
    // rate 10 is nominal, 0 is stuck
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            acc_reg <= 5'h00;
        end else begin
            acc_reg <= acc_reg + osc_rate;
        end
    end
    assign ref_osc = acc_reg[4];
endmodule : analog_side_model

// [verification/testbench.sv]
// self-checking bench of the supply monitor self-test block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import supply_monitor_pkg::*;
    localparam int MH = 8;
    localparam int GT = 16;
    logic        sys_clk, rst, en_wr, flt_rd, tmp_rd, sts_rd, wake, trim_done, stuck_lvl;
    logic        mon_chop, gnd_chop, gnd_busy, rst_p_n, rst_s_n, ch_dis, ref_osc, chop_q;
    logic [1:0]  uv, ov, gnd_stuck, gnd_cmp;
    logic [3:0]  mon_stuck, mon_cmp;
    logic [4:0]  osc_rate;
    logic [15:0] lfsr_reg;
    reg_word_t   en_wdata, en_rdata, flt_rdata, tmp_rdata;
    int          err_count, total_checks, n;

    supply_monitor_self_test #(.MON_HALF(MH), .GND_HALF(4), .GND_TEST(GT), .RESET_HOLD(4),
        .PWR_DOWN(2), .OSC_WINDOW(64), .OSC_STUCK(8)) uut (
        .sys_clk(sys_clk), .rst(rst), .service_enable_wr(en_wr), .service_enable_wdata(en_wdata),
        .service_enable_rdata(en_rdata), .service_fault_rd(flt_rd), .service_fault_rdata(flt_rdata),
        .temperature_sensor_rd(tmp_rd), .temperature_sensor_rdata(tmp_rdata),
        .supply_status_rd(sts_rd), .uv_fault_flag(uv), .ov_fault_flag(ov), .mon_chop_clk(mon_chop),
        .mon_cmp_out(mon_cmp), .ref_osc(ref_osc), .wake(wake), .trim_done(trim_done),
        .gnd_chop_clk(gnd_chop), .gnd_cmp_out(gnd_cmp), .gnd_test_busy(gnd_busy),
        .reset_out_primary_n(rst_p_n), .reset_out_secondary_n(rst_s_n), .channels_disable(ch_dis));

    analog_side_model far_side (
        .sys_clk(sys_clk), .rst(rst), .mon_chop_clk(mon_chop), .gnd_chop_clk(gnd_chop),
        .mon_stuck(mon_stuck), .gnd_stuck(gnd_stuck), .stuck_lvl(stuck_lvl), .osc_rate(osc_rate),
        .mon_cmp_out(mon_cmp), .gnd_cmp_out(gnd_cmp), .ref_osc(ref_osc));

    always #10 sys_clk = ~sys_clk;

    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr_next

    function automatic logic [3:0] exp_flags(input int idx);
        return 4'h1 << idx;
    endfunction : exp_flags

    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk);
        #2;
    endtask : tick

    task automatic chk(input reg_word_t seen, input reg_word_t exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // other bits carry random junk: only the enable bit may be stored
    task automatic wr_en(input logic v);
        lfsr_reg = lfsr_next(lfsr_reg);
        en_wdata = {lfsr_reg[2:0], v, lfsr_reg};
        en_wr = 1'b1;
        tick(1);
        en_wr = 1'b0;
    endtask : wr_en

    // sel 0 watches the primary reset, sel 1 the channel disable
    task automatic wait_on(input int sel, input logic lvl, input int lim);
        int i;
        i = 0;
        while (((sel == 0) ? rst_p_n : ch_dis) !== lvl && i < lim) begin
            tick(1);
            i++;
        end
        chk(reg_word_t'(i < lim), 20'h0_0001);
    endtask : wait_on

    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        #400000;
        err_count++;
        report_and_stop();
    end

    initial begin
        {sys_clk, en_wr, flt_rd, tmp_rd, sts_rd, wake, trim_done, stuck_lvl} = '0;
        {mon_stuck, gnd_stuck, en_wdata} = '0;
        osc_rate = 5'h0A;
        lfsr_reg = 16'h426A;
        rst = 1'b1;
        tick(20);
        rst = 1'b0;
        chk(reg_word_t'({rst_p_n, rst_s_n, ch_dis}), 20'h0_0001);
        wr_en(1'b1);
        wait_on(0, 1'b1, 20);
        chk(en_rdata, 20'h0_0000);
        wr_en(1'b1);
        n = 0;
        repeat (10 * MH) begin
            chop_q = mon_chop;
            tick(1);
            n += int'(mon_chop !== chop_q);
        end
        chk(reg_word_t'(n), reg_word_t'(10));
        chk(en_rdata, 20'h1_0000);
        chk(flt_rdata, 20'h0_0000);
        wr_en(1'b0);
        tick(2);
        chk(reg_word_t'(mon_chop), 20'h0_0000);
        for (int i = 0; i < 4; i++) begin
            lfsr_reg = lfsr_next(lfsr_reg);
            stuck_lvl = lfsr_reg[0];
            mon_stuck = 4'h1 << i;
            // one pass reads both flag registers on the failing edge: the new fault must win
            {flt_rd, sts_rd} = {2{i == 2}};
            wr_en(1'b1);
            wait_on(0, 1'b0, 4 * MH);
            {flt_rd, sts_rd} = 2'b00;
            mon_stuck = 4'h0;
            chk(reg_word_t'({ov[1], uv[1], ov[0], uv[0]}), reg_word_t'(exp_flags(i)));
            chk(flt_rdata, 20'h0_0400);
            wait_on(0, 1'b1, 20);
            chk(en_rdata, 20'h0_0000);
            chk(flt_rdata, 20'h0_0400);
            flt_rd = 1'b1;
            sts_rd = 1'b1;
            tick(1);
            {flt_rd, sts_rd} = 2'b00;
            chk(flt_rdata | reg_word_t'({uv, ov}), 20'h0_0000);
        end
        for (int r = 0; r < 2; r++) begin
            osc_rate = (r == 0) ? 5'h0F : 5'h00;
            wait_on(0, 1'b0, 250);
            chk(reg_word_t'({rst_s_n, ch_dis}), 20'h0_0001);
            wake = r[0];
            flt_rd = 1'b1;
            tick(1);
            flt_rd = 1'b0;
            chk(flt_rdata, 20'h0_8000);
            tick(40);
            chk(reg_word_t'(ch_dis), 20'h0_0001);
            osc_rate = 5'h0A;
            wake = 1'b0;
            wait_on(1, 1'b0, 400);
            flt_rd = 1'b1;
            tick(1);
            flt_rd = 1'b0;
            chk(flt_rdata, 20'h0_0000);
        end
        for (int j = 0; j < 3; j++) begin
            lfsr_reg = lfsr_next(lfsr_reg);
            stuck_lvl = lfsr_reg[0];
            gnd_stuck = j[1:0];
            trim_done = 1'b1;
            n = 0;
            for (int c = 0; c < 3 * GT; c++) begin
                tick(1);
                n += int'(gnd_busy === 1'b1);
                trim_done = (c != 5);
            end
            trim_done = 1'b0;
            chk(reg_word_t'(n), reg_word_t'(GT));
            chk(tmp_rdata, reg_word_t'(j) << 10);
            chk(reg_word_t'(rst_p_n), 20'h0_0001);
            tmp_rd = 1'b1;
            tick(1);
            tmp_rd = 1'b0;
            chk(tmp_rdata, 20'h0_0000);
        end
        report_and_stop();
    end
endmodule : testbench
